// ### inc/cesq_map.svh
// offsets-free constants: field codes, reset values and timing counts of the sequencer
`ifndef CESQ_MAP_SVH
`define CESQ_MAP_SVH
// ============================================================
// timing
`define CESQ_CLK_MHZ          50
`define CESQ_RESET_TIME_US    100
`define CESQ_RESET_CYCLES     (`CESQ_RESET_TIME_US * `CESQ_CLK_MHZ)
`define CESQ_TIMEOUT_DEF      32'd1000
`define CESQ_STEP_CYCLES      16'd4
// ============================================================
// data-line level codes
`define CESQ_LVL_W            3
`define CESQ_LVL_LOW          3'h0
`define CESQ_LVL_A            3'h1
`define CESQ_LVL_B            3'h2
`define CESQ_LVL_C            3'h3
`define CESQ_LVL_D            3'h4
`define CESQ_LVL_900MV        3'h5
`define CESQ_LVL_DIV          3'h6
// ============================================================
// profile indices in default order
`define CESQ_NPROF            9
`define CESQ_P_LEG1           4'h0
`define CESQ_P_DCP            4'h1
`define CESQ_P_LEG2           4'h2
`define CESQ_P_LEG3           4'h3
`define CESQ_P_LEG4           4'h4
`define CESQ_P_LEG5           4'h5
`define CESQ_P_LEG6           4'h6
`define CESQ_P_LEG7           4'h7
`define CESQ_P_CUST           4'h8
`define CESQ_P_NONE           4'hF
`endif

// ### inc/cesq_pkg.sv
// types shared by the emulation sequencer files
package cesq_pkg;
    typedef logic [3:0] cesq_prof_t;
    typedef logic [2:0] cesq_lvl_t;
    typedef enum logic [2:0] {
        CESQ_IDLE,
        CESQ_RESET,
        CESQ_SELECT,
        CESQ_SIGNAL,
        CESQ_APPLY,
        CESQ_CUSTOM,
        CESQ_DONE
    } cesq_state_e;
endpackage : cesq_pkg

// ### rtl/cesq_timer.sv
// one-shot down counter with expiry pulse
`timescale 1ns/1ps
module cesq_timer
    import cesq_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              expired
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;
    logic         exp_q;
    logic         exp_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (load) begin
            cnt_d = (value == '0) ? W'(1) : value;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == W'(1)) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule : cesq_timer

// ### rtl/cesq_sequencer.sv
// dedicated emulation cycle profile sequencer
// ============================================================
// Behaviour
// - dcp profile in cycle is qualified by profile timeout timer
// - dcp accepted: flag, keep short, switch open, constant current
// - dcp rejected: drop signature, advance to next profile
// - legacy 2: connect short resistor first, then apply vbus
// - legacy 2 accepted: charging, keep short, constant current
// - legacy 2 rejected: remove short, emulation reset, next profile
// - legacy 1,3,4,6: drive per-profile line levels before vbus
// - legacy accept: keep levels unless keep bit clear; mode min
// - legacy reject: remove both line levels, reset, next profile
// - legacy 5: same fixed level on both lines, then vbus
// - legacy 7: only d+ via divider, then vbus; reject clears it
// - legacy 7 accept: keep d+ unless keep bit clear; min mode
// - custom profile may join cycle, placed first or last
// - custom runs three stimulus/response pairs strictly in order
// - order legacy1, dcp, legacy2..7, custom; custom first if set
// - emulation reset: switch open, discharge, hold, lines low
`timescale 1ns/1ps
`include "cesq_map.svh"
module cesq_sequencer
    import cesq_pkg::*;
#(
    parameter int RESET_CYCLES = `CESQ_RESET_CYCLES,
    parameter int TW           = 32
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          cycle_enable,
    input  wire logic [8:0]    profile_enable,
    input  wire logic          custom_profile_first,
    input  wire logic          keep_response_after_accept,
    input  wire logic          r2_min_current_threshold,
    input  wire logic          charge_detect_current,
    input  wire logic [TW-1:0] profile_timeout,
    input  wire logic          custom_response_met,
    output logic [2:0]         port_dplus_line,
    output logic [2:0]         port_dminus_line,
    output logic               data_line_short_resistor,
    output logic               vbus_switch_closed,
    output logic               vbus_discharge,
    output logic               hs_switch_closed,
    output logic               cc_mode,
    output logic               dcp_detected,
    output logic               charging,
    output logic [3:0]         applied_profile,
    output logic [1:0]         custom_stage
);
    // ============================================================
    // state
    cesq_state_e  st_q,  st_d;
    cesq_prof_t   pos_q, pos_d;
    cesq_prof_t   prof_q, prof_d;
    logic [31:0]  rst_q, rst_d;
    logic [1:0]   stg_q, stg_d;
    cesq_lvl_t    dp_q, dp_d, dm_q, dm_d;
    logic         sh_q, sh_d, sw_q, sw_d, dis_q, dis_d;
    logic         cc_q, cc_d, dcp_q, dcp_d, chg_q, chg_d;
    logic         hs_q, hs_d, decide;
    logic         tload;
    logic         texp;

    cesq_timer #(.W(TW)) u_timer (
        .clk     (clk),
        .reset   (reset),
        .load    (tload),
        .value   (profile_timeout),
        .expired (texp)
    );

    function automatic cesq_prof_t order_at(input cesq_prof_t p, input logic cf);
        cesq_prof_t r;
        r = p;
        if (cf) begin
            r = (p == 4'h0) ? `CESQ_P_CUST : 4'(p - 4'h1);
        end
        return r;
    endfunction : order_at

    always_comb begin
        st_d = st_q; pos_d = pos_q; prof_d = prof_q; rst_d = rst_q; stg_d = stg_q;
        dp_d = dp_q; dm_d = dm_q; sh_d = sh_q; sw_d = sw_q; dis_d = dis_q;
        cc_d = cc_q; dcp_d = dcp_q; chg_d = chg_q;
        tload = 1'b0;
        hs_d = 1'b0;
        decide = 1'b0;
        case (st_q)
            CESQ_IDLE: begin
                if (cycle_enable) begin
                    pos_d = 4'h0;
                    rst_d = 32'(RESET_CYCLES);
                    st_d  = CESQ_RESET;
                end
            end
            CESQ_RESET: begin
                sw_d = 1'b0; dis_d = 1'b1; sh_d = 1'b0;
                dp_d = `CESQ_LVL_LOW; dm_d = `CESQ_LVL_LOW;
                prof_d = `CESQ_P_NONE;
                rst_d = rst_q - 32'd1;
                // discharge ends in select so it spans the full reset count
                if (rst_q <= 32'd1) begin
                    st_d  = CESQ_SELECT;
                end
            end
            CESQ_SELECT: begin
                dis_d = 1'b0;
                if (pos_q >= 4'(`CESQ_NPROF)) begin
                    pos_d = 4'h0;       // wrap, keep retrying while enabled
                    rst_d = 32'(RESET_CYCLES);
                    st_d  = CESQ_RESET;
                end else if (profile_enable[order_at(pos_q, custom_profile_first)]) begin
                    prof_d = order_at(pos_q, custom_profile_first);
                    rst_d  = 32'd0;
                    st_d   = CESQ_SIGNAL;
                end else begin
                    pos_d = pos_q + 4'h1;
                end
            end
            // signature in the first cycle, vbus only in the second
            CESQ_SIGNAL: begin
                if (rst_q == 32'd0) begin
                    rst_d = 32'd1;
                    case (prof_q)
                        `CESQ_P_DCP, `CESQ_P_LEG2: sh_d = 1'b1;
                        `CESQ_P_LEG1: begin dp_d = `CESQ_LVL_A; dm_d = `CESQ_LVL_B; end
                        `CESQ_P_LEG3: begin dp_d = `CESQ_LVL_B; dm_d = `CESQ_LVL_A; end
                        `CESQ_P_LEG4: begin dp_d = `CESQ_LVL_C; dm_d = `CESQ_LVL_C; end
                        `CESQ_P_LEG6: begin dp_d = `CESQ_LVL_D; dm_d = `CESQ_LVL_B; end
                        `CESQ_P_LEG5: begin dp_d = `CESQ_LVL_900MV; dm_d = `CESQ_LVL_900MV; end
                        `CESQ_P_LEG7: dp_d = `CESQ_LVL_DIV;
                        default: ;
                    endcase
                end else begin
                    rst_d = 32'd0;
                    sw_d  = 1'b1;
                    cc_d  = 1'b1;
                    stg_d = 2'd0;
                    tload = 1'b1;
                    st_d  = (prof_q == `CESQ_P_CUST) ? CESQ_CUSTOM : CESQ_APPLY;
                end
            end
            CESQ_CUSTOM: begin
                if (custom_response_met && stg_q != 2'd3) begin
                    stg_d = stg_q + 2'd1;
                end
                decide = texp;
            end
            CESQ_APPLY: begin
                decide = texp;
            end
            CESQ_DONE: begin
                if (!cycle_enable) begin
                    st_d = CESQ_IDLE; chg_d = 1'b0; dcp_d = 1'b0;
                end
            end
            default: st_d = CESQ_IDLE;
        endcase
        // single sample at expiry, custom included
        if (decide) begin
            if (charge_detect_current && (prof_q != `CESQ_P_CUST || stg_q == 2'd3)) begin
                chg_d = 1'b1;
                st_d  = CESQ_DONE;
                if (prof_q == `CESQ_P_DCP || prof_q == `CESQ_P_LEG2) begin
                    cc_d  = 1'b1;
                    dcp_d = (prof_q == `CESQ_P_DCP);
                end else begin
                    cc_d = ~r2_min_current_threshold;
                    if (!keep_response_after_accept) begin
                        dp_d = `CESQ_LVL_LOW;
                        dm_d = `CESQ_LVL_LOW;
                    end
                end
            end else begin
                sh_d  = 1'b0;
                dp_d  = `CESQ_LVL_LOW;
                dm_d  = `CESQ_LVL_LOW;
                pos_d = pos_q + 4'h1;
                rst_d = 32'(RESET_CYCLES);
                st_d  = CESQ_RESET;
            end
        end
        if (!cycle_enable && st_q != CESQ_IDLE) begin
            st_d = CESQ_IDLE; sw_d = 1'b0; sh_d = 1'b0; dis_d = 1'b0;
            dp_d = `CESQ_LVL_LOW; dm_d = `CESQ_LVL_LOW; chg_d = 1'b0; dcp_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= CESQ_IDLE; pos_q <= 4'h0; prof_q <= `CESQ_P_NONE; rst_q <= 32'h0;
            stg_q <= 2'h0; dp_q <= `CESQ_LVL_LOW; dm_q <= `CESQ_LVL_LOW;
            sh_q <= 1'b0; sw_q <= 1'b0; dis_q <= 1'b0;
            cc_q <= 1'b0; dcp_q <= 1'b0; chg_q <= 1'b0;
            hs_q <= 1'b0;
        end else begin
            st_q <= st_d; pos_q <= pos_d; prof_q <= prof_d; rst_q <= rst_d;
            stg_q <= stg_d; dp_q <= dp_d; dm_q <= dm_d;
            sh_q <= sh_d; sw_q <= sw_d; dis_q <= dis_d;
            cc_q <= cc_d; dcp_q <= dcp_d; chg_q <= chg_d;
            hs_q <= hs_d;
        end
    end

    assign port_dplus_line          = dp_q;
    assign port_dminus_line         = dm_q;
    assign data_line_short_resistor = sh_q;
    assign vbus_switch_closed       = sw_q;
    assign vbus_discharge           = dis_q;
    // high-speed switch held open in cycle
    assign hs_switch_closed         = hs_q;
    assign cc_mode                  = cc_q;
    assign dcp_detected             = dcp_q;
    assign charging                 = chg_q;
    assign applied_profile          = prof_q;
    assign custom_stage             = stg_q;

    // ============================================================
    // checks
    // reset opens switch
    a_reset_opens_sw: assert property (@(posedge clk) disable iff (reset)
        (st_q == CESQ_RESET) |=> !sw_q) else $error("switch closed during reset");
    a_short_before_vbus: assert property (@(posedge clk) disable iff (reset)
        (prof_q == `CESQ_P_LEG2 && $rose(sw_q)) |-> $past(sh_q)) else $error("short missing");
    a_dcp_keeps_short: assert property (@(posedge clk) disable iff (reset)
        dcp_q |-> sh_q && cc_q && !hs_switch_closed) else $error("dcp accept wrong");
    a_reject_clears: assert property (@(posedge clk) disable iff (reset)
        (st_q == CESQ_APPLY && texp && !charge_detect_current && cycle_enable)
        |=> dp_q == 3'h0 && dm_q == 3'h0 && !sh_q) else $error("reject left levels");
    a_accept_sampled: assert property (@(posedge clk) disable iff (reset)
        (st_q == CESQ_APPLY && texp && charge_detect_current && prof_q != 4'h8 && cycle_enable)
        |=> chg_q) else $error("accept missed");
    a_leg7_dplus: assert property (@(posedge clk) disable iff (reset)
        (st_q == CESQ_APPLY && prof_q == 4'h7) |-> dm_q == 3'h0) else $error("legacy7 drove d-");
    a_leg5_equal: assert property (@(posedge clk) disable iff (reset)
        (st_q == CESQ_APPLY && prof_q == 4'h5) |-> dp_q == dm_q) else $error("legacy5 unequal");
    a_stage_steps: assert property (@(posedge clk) disable iff (reset)
        (st_q == CESQ_CUSTOM) |=> (stg_q == $past(stg_q) || stg_q == $past(stg_q) + 2'd1))
        else $error("custom stage jumped");
    c_dcp_accept:  cover property (@(posedge clk) disable iff (reset) $rose(dcp_q));
    c_leg_accept:  cover property (@(posedge clk) disable iff (reset) $rose(chg_q) && !dcp_q);
    c_custom_done: cover property (@(posedge clk) disable iff (reset) stg_q == 2'd3);
endmodule : cesq_sequencer

// ### tb/cesq_portable_model.sv
// portable device model that draws charge current on one chosen profile
`timescale 1ns/1ps
module cesq_portable_model
    import cesq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] accept_profile,
    input  wire logic [7:0] draw_lag,
    input  wire logic [3:0] applied_profile,
    input  wire logic       vbus_switch_closed,
    output logic            charge_detect_current
);
    // ============================================================
    // load behaviour
    logic [7:0] powered_q;

    // device wakes slowly: a lag longer than the timeout means a late draw
    always_ff @(posedge clk) begin
        if (reset || !vbus_switch_closed)
            powered_q <= 8'h00;
        else if (powered_q != 8'hFF)
            powered_q <= powered_q + 8'h01;
    end

    assign charge_detect_current = vbus_switch_closed && (applied_profile == accept_profile) && (powered_q > draw_lag);
endmodule : cesq_portable_model

// ### tb/testbench.sv
// self-checking bench for the emulation cycle sequencer
`timescale 1ns/1ps
`include "cesq_map.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench
    import cesq_pkg::*;
;
    localparam int RC = 20;
    localparam int TO = 8;
    logic clk = 1'b0, reset = 1'b1, cycle_enable = 1'b0, custom_profile_first = 1'b0;
    logic keep_response_after_accept = 1'b0, r2_min_current_threshold = 1'b0, custom_response_met = 1'b0;
    logic [8:0] profile_enable = 9'h000;
    logic [3:0] accept_profile = 4'hF, applied_profile;
    logic [1:0] custom_stage;
    logic [7:0] draw_lag = 8'h02;
    logic [2:0] port_dplus_line, port_dminus_line;
    logic charge_detect_current, data_line_short_resistor, vbus_switch_closed, vbus_discharge;
    logic hs_switch_closed, cc_mode, dcp_detected, charging, sw_prev = 1'b0, reset_bad = 1'b0;
    int n_mismatch = 0, tests_run = 0, disch_run = 0, disch_last = 0, cyc = 0;
    cesq_prof_t order_q[$];

    cesq_sequencer #(.RESET_CYCLES(RC), .TW(32)) i_cesq_sequencer (
        .clk(clk), .reset(reset), .cycle_enable(cycle_enable), .profile_enable(profile_enable),
        .custom_profile_first(custom_profile_first), .keep_response_after_accept(keep_response_after_accept),
        .r2_min_current_threshold(r2_min_current_threshold), .charge_detect_current(charge_detect_current),
        .profile_timeout(32'(TO)), .custom_response_met(custom_response_met), .port_dplus_line(port_dplus_line),
        .port_dminus_line(port_dminus_line), .data_line_short_resistor(data_line_short_resistor),
        .vbus_switch_closed(vbus_switch_closed), .vbus_discharge(vbus_discharge), .hs_switch_closed(hs_switch_closed),
        .cc_mode(cc_mode), .dcp_detected(dcp_detected), .charging(charging), .applied_profile(applied_profile),
        .custom_stage(custom_stage));
    cesq_portable_model i_cesq_portable_model (
        .clk(clk), .reset(reset), .accept_profile(accept_profile), .draw_lag(draw_lag),
        .applied_profile(applied_profile), .vbus_switch_closed(vbus_switch_closed),
        .charge_detect_current(charge_detect_current));

    initial begin
        forever #10 clk = ~clk;
    end
    // ============================================================
    // tasks
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic wait_for(input int kind, input int n);
        for (int i = 0; i < 3000; i++) begin
            if (kind == 0 ? order_q.size() >= n : (charging === 1'b1 || dcp_detected === 1'b1))
                break;
            step(1);
        end
    endtask : wait_for
    task automatic start(input logic [8:0] en, input logic first, keep, r2, input cesq_prof_t acc, input int lag);
        cycle_enable = 1'b0;
        step(3);
        profile_enable = en;
        custom_profile_first = first;
        keep_response_after_accept = keep;
        r2_min_current_threshold = r2;
        accept_profile = acc;
        draw_lag = 8'(lag);
        order_q.delete();
        cycle_enable = 1'b1;
    endtask : start
    task automatic check_sig(input cesq_prof_t p);
        if (p == `CESQ_P_DCP || p == `CESQ_P_LEG2)
            `CHK("short_on", 1'b1, data_line_short_resistor)
        else
            `CHK("short_off", 1'b0, data_line_short_resistor)
        if (p == `CESQ_P_LEG5) begin
            `CHK("dp_900", `CESQ_LVL_900MV, port_dplus_line)
            `CHK("dm_900", `CESQ_LVL_900MV, port_dminus_line)
        end
        if (p == `CESQ_P_LEG7) begin
            `CHK("dp_div", `CESQ_LVL_DIV, port_dplus_line)
            `CHK("dm_low", `CESQ_LVL_LOW, port_dminus_line)
        end
        if (p inside {`CESQ_P_LEG1, `CESQ_P_LEG3, `CESQ_P_LEG4, `CESQ_P_LEG6}) begin
            `CHK("dp_set", 1'b1, port_dplus_line != `CESQ_LVL_LOW)
            `CHK("dm_set", 1'b1, port_dminus_line != `CESQ_LVL_LOW)
        end
    endtask : check_sig
    task automatic accept(input cesq_prof_t p, input logic keep, r2, lines, input logic [2:0] dp, dm, input logic cc);
        start(9'h1FF, 1'b0, keep, r2, p, 2);
        wait_for(1, 0);
        step(4);
        `CHK("applied", p, applied_profile)
        `CHK("cc_mode", cc, cc_mode)
        `CHK("vbus_on", 1'b1, vbus_switch_closed)
        `CHK("hs_open", 1'b0, hs_switch_closed)
        `CHK("short_kept", p == `CESQ_P_DCP || p == `CESQ_P_LEG2, data_line_short_resistor)
        `CHK("accepted", 1'b1, (p == `CESQ_P_DCP) ? dcp_detected : charging)
        `CHK("no_advance", 1'b1, order_q.size() == p + 1)
        if (lines) begin
            `CHK("dp_kept", dp, port_dplus_line)
            `CHK("dm_kept", dm, port_dminus_line)
        end
        $display("test accept %0h done", p);
    endtask : accept
    // ============================================================
    // monitor: reset phase and signature at each vbus turn-on
    always @(posedge clk) begin
        sw_prev <= vbus_switch_closed;
        cyc <= cyc + 1;
        if (vbus_discharge === 1'b1) begin
            disch_run <= disch_run + 1;
            if ({vbus_switch_closed, data_line_short_resistor, port_dplus_line, port_dminus_line} !== 8'h00)
                reset_bad <= 1'b1;
        end else if (disch_run != 0) begin
            disch_last <= disch_run;
            disch_run <= 0;
        end
        if (vbus_switch_closed === 1'b1 && sw_prev === 1'b0) begin
            order_q.push_back(applied_profile);
            `CHK("reset_len", RC, disch_last)
            check_sig(applied_profile);
        end
        // ceiling well above the roughly 1500 cycles the tests need
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ============================================================
    // tests
    initial begin
        step(6);
        reset = 1'b0;
        step(1);
        `CHK("rst_applied", 4'hF, applied_profile)
        `CHK("rst_switch", 1'b0, vbus_switch_closed)
        `CHK("rst_charging", 1'b0, charging)
        $display("test reset done");
        start(9'h1FF, 1'b0, 1'b1, 1'b1, 4'hF, 2);
        wait_for(0, 10);
        for (int i = 0; i < 9; i++)
            `CHK("order", cesq_prof_t'(i), order_q[i])
        `CHK("order_wrap", `CESQ_P_LEG1, order_q[9])
        `CHK("none_taken", 1'b0, charging | dcp_detected)
        $display("test full cycle done");
        start(9'h103, 1'b1, 1'b1, 1'b1, 4'hF, 2);
        wait_for(0, 3);
        `CHK("cf_0", `CESQ_P_CUST, order_q[0])
        `CHK("cf_1", `CESQ_P_LEG1, order_q[1])
        `CHK("cf_2", `CESQ_P_DCP, order_q[2])
        $display("test custom first done");
        accept(`CESQ_P_DCP, 1'b1, 1'b1, 1'b0, 3'h0, 3'h0, 1'b1);
        accept(`CESQ_P_LEG2, 1'b1, 1'b1, 1'b0, 3'h0, 3'h0, 1'b1);
        accept(`CESQ_P_LEG5, 1'b1, 1'b1, 1'b1, `CESQ_LVL_900MV, `CESQ_LVL_900MV, 1'b0);
        accept(`CESQ_P_LEG1, 1'b0, 1'b0, 1'b1, `CESQ_LVL_LOW, `CESQ_LVL_LOW, 1'b1);
        accept(`CESQ_P_LEG7, 1'b1, 1'b0, 1'b1, `CESQ_LVL_DIV, `CESQ_LVL_LOW, 1'b1);
        accept(`CESQ_P_LEG7, 1'b0, 1'b1, 1'b1, `CESQ_LVL_LOW, `CESQ_LVL_LOW, 1'b0);
        start(9'h003, 1'b0, 1'b1, 1'b1, `CESQ_P_LEG1, TO + 5);
        wait_for(0, 2);
        `CHK("late_draw", `CESQ_P_DCP, order_q[1])
        `CHK("late_none", 1'b0, charging)
        $display("test late draw done");
        custom_response_met = 1'b1;
        start(9'h100, 1'b0, 1'b1, 1'b1, `CESQ_P_CUST, 2);
        wait_for(1, 0);
        step(2);
        `CHK("cust_chg", 1'b1, charging)
        `CHK("cust_app", `CESQ_P_CUST, applied_profile)
        `CHK("cust_stage", 2'h3, custom_stage)
        cycle_enable = 1'b0;
        custom_response_met = 1'b0;
        step(3);
        `CHK("abort_chg", 1'b0, charging)
        `CHK("abort_sw", 1'b0, vbus_switch_closed)
        `CHK("reset_clean", 1'b0, reset_bad)
        $display("test custom and abort done");
        report_and_stop();
    end
endmodule : testbench
